// >>> bench/ppp_port_sva.sv
/* checker of the programming port, bound to its top module.
   assumes strobes sampled on sys_clk_i as in the design. */
`timescale 1ns/1ps
`default_nettype none
`include "ppp_defs.vh"
module ppp_port_sva #(
    parameter int BYTE_PROG_CYC = 28000
) (
    input wire logic       sys_clk_i,
    input wire logic       rstn_i,
    input wire logic       load_strobe_clock_i,
    input wire logic       strobe_action_bit0_i,
    input wire logic       strobe_action_bit1_i,
    input wire logic       byte_select_i,
    input wire logic       write_n_i,
    input wire logic       output_en_n_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_n_o,
    input wire logic       ready_busy_flag_o,
    input wire logic [1:0] lock_bits_o,
    input wire logic [1:0] fuse_bits_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic       ls_q, wr_q;
    logic [7:0] cmd_q, dlo_q;
    int         busy_cnt;
    wire logic [1:0] act = {strobe_action_bit1_i, strobe_action_bit0_i};
    wire logic ld = load_strobe_clock_i && !ls_q;
    wire logic wf = !write_n_i && wr_q;
    wire logic rdc = cmd_q inside {8'h02, 8'h03, 8'h04, 8'h08};
    wire logic [1:0] fz_new = {dlo_q[5], dlo_q[0]};
    wire logic [1:0] lk_new = lock_bits_o & {dlo_q[2], dlo_q[1]};
    // ==================================================================
    // mirror of latched command and data low byte, busy length counter
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {ls_q, wr_q, cmd_q, dlo_q} <= {2'b01, 8'h00, 8'hFF};
            busy_cnt <= 0;
        end else begin
            {ls_q, wr_q} <= {load_strobe_clock_i, write_n_i};
            if (ld && act == `PPP_ACT_CMD) cmd_q <= data_i;
            if (ld && act == `PPP_ACT_DATA && !byte_select_i) dlo_q <= data_i;
            busy_cnt <= ready_busy_flag_o ? 0 : busy_cnt + 1;
        end
    end
    bus_idle_a: assert property (output_en_n_i |-> data_oe_n_o)
        else $error("bus driven without output enable");
    bus_enable_a: assert property ($stable(cmd_q) |->
        data_oe_n_o == !(!output_en_n_i && rdc))
        else $error("bus enable does not follow read command");
    fuse_ready_a: assert property (wf && cmd_q == `PPP_CMD_WR_FUSE
        && ready_busy_flag_o |=> ready_busy_flag_o [*8])
        else $error("busy seen during fuse write");
    fuse_write_a: assert property (wf && cmd_q == `PPP_CMD_WR_FUSE
        |=> fuse_bits_o == $past(fz_new))
        else $error("fuse bits not taken from data bits 5 and 0");
    lock_write_a: assert property (wf && cmd_q == `PPP_CMD_WR_LOCK
        && !byte_select_i |=> lock_bits_o == $past(lk_new))
        else $error("lock bits not programmed from data bits 2 and 1");
    lock_clear_a: assert property ((lock_bits_o & ~$past(lock_bits_o))
        != 2'b00 |-> cmd_q == `PPP_CMD_ERASE)
        else $error("lock bit cleared without erase");
    erase_lock_a: assert property (wf && cmd_q == `PPP_CMD_ERASE
        && ready_busy_flag_o |-> ##[2:3] lock_bits_o == 2'b11)
        else $error("erase left lock bits programmed");
    erase_fuse_a: assert property (wf && cmd_q == `PPP_CMD_ERASE
        |=> $stable(fuse_bits_o) [*3])
        else $error("erase changed fuse bits");
    busy_bound_a: assert property (!ready_busy_flag_o
        |-> busy_cnt < BYTE_PROG_CYC)
        else $error("busy longer than programming time");
    long_write_a: assert property (!write_n_i && !wr_q
        |-> ready_busy_flag_o)
        else $error("busy shown while write strobe low");
    lock_rb_a: assert property (cmd_q == `PPP_CMD_RD_LOCK
        && $past(cmd_q) == `PPP_CMD_RD_LOCK && byte_select_i
        && $past(byte_select_i) && $stable(lock_bits_o)
        && $stable(fuse_bits_o) |-> data_o == {lock_bits_o[0],
        lock_bits_o[1], fuse_bits_o[1], 4'hF, fuse_bits_o[0]})
        else $error("lock and fuse readback misplaced");
endmodule // ppp_port_sva
bind ppp_port ppp_port_sva #(.BYTE_PROG_CYC(BYTE_PROG_CYC)) i_ppp_port_sva (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .load_strobe_clock_i(load_strobe_clock_i),
    .strobe_action_bit0_i(strobe_action_bit0_i),
    .strobe_action_bit1_i(strobe_action_bit1_i),
    .byte_select_i(byte_select_i), .write_n_i(write_n_i),
    .output_en_n_i(output_en_n_i), .data_i(data_i), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .ready_busy_flag_o(ready_busy_flag_o),
    .lock_bits_o(lock_bits_o), .fuse_bits_o(fuse_bits_o));
`default_nettype wire

// >>> bench/ppp_port_test.sv
/* top bench: programmer model, read expectations in a queue.
   assumes rtl/ppp_port.v and a 40 MHz clock; short program time. */
`timescale 1ns/1ps
`default_nettype none
`include "ppp_defs.vh"
module ppp_port_test;
    localparam int BPC = 20;
    // signature values are arbitrary; index 3 reads as erased
    localparam logic [7:0] SIG [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hFF};
    localparam logic [1:0] AD = `PPP_ACT_ADDR;
    localparam logic [1:0] DT = `PPP_ACT_DATA;
    logic       sys_clk, rstn, ls, bs, wr_n, oe_n, smp, oe_dev_n, rdy;
    logic [1:0] act, lock, fuse;
    logic [7:0] bus, dout;
    logic [8:0] exp_q [$];
    logic [31:0] rnd = 32'h65ad;
    logic [7:0] wal [4], wlo [4], whi [4];
    logic [7:0] lk_d [3] = '{8'hFD, 8'hFB, 8'hFF};
    logic [1:0] lk_e [3] = '{2'b10, 2'b00, 2'b00};
    int failures = 0;
    int n_checks = 0;
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    ppp_port #(.BYTE_PROG_CYC(BPC), .SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]),
        .SIG_BYTE2(SIG[2])) i_ppp_port (.sys_clk_i(sys_clk), .rstn_i(rstn),
        .load_strobe_clock_i(ls), .strobe_action_bit0_i(act[0]),
        .strobe_action_bit1_i(act[1]), .byte_select_i(bs),
        .write_n_i(wr_n), .output_en_n_i(oe_n), .data_i(bus),
        .data_o(dout), .data_oe_n_o(oe_dev_n), .ready_busy_flag_o(rdy),
        .lock_bits_o(lock), .fuse_bits_o(fuse));
    ppp_prog i_ppp_prog (.clk_i(sys_clk), .dev_data_i(dout),
        .dev_oe_n_i(oe_dev_n), .ls_o(ls), .act_o(act), .bs_o(bs),
        .wr_n_o(wr_n), .oe_n_o(oe_n), .smp_o(smp), .bus_o(bus));
    // ==================================================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic ck(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            $display("unexpected %0t %s", $time, m);
            failures++;
        end
    endtask
    task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
        i_ppp_prog.ld(a, b, d);
    endtask
    // expectation {bus released, data}, noted before the read starts
    task automatic rd(input logic b, input logic [8:0] e);
        exp_q.push_back(e);
        i_ppp_prog.rd(b);
    endtask
    // byte write; busy must show, then end inside the scaled window
    task automatic wrb(input logic b);
        int n;
        i_ppp_prog.wr(b, 1);
        @(negedge sys_clk);
        ck(rdy === 1'b0, "no busy after byte write");
        n = 2;
        while (rdy !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        ck(n >= BPC * 5 / 7 && n <= BPC * 9 / 7, "ready timing");
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // result watcher: oldest note against the sampled outputs
    always @(posedge sys_clk) begin
        logic [8:0] e;
        if (smp) begin
            e = exp_q.pop_front();
            ck(oe_dev_n === e[8], "bus enable");
            if (!e[8]) ck(dout === e[7:0], "read data");
        end
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        report_and_stop();
    end
    initial begin
        rstn = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        ck(rdy === 1'b1 && lock === 2'b11 && fuse === 2'b11, "reset");
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_ERASE);
        i_ppp_prog.wr(1'b0, 6);
        // one command, one page: only the low address moves per word
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FLASH);
        ld(AD, 1'b1, 8'h05);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wal[i] = {rnd[7:2], 2'(i)};
            wlo[i] = rnd[15:8] & 8'hFE;
            whi[i] = rnd[23:16] & 8'hFE;
            ld(AD, 1'b0, wal[i]);
            ld(DT, 1'b0, wlo[i]);
            wrb(1'b0);
            ld(DT, 1'b1, whi[i]);
            wrb(1'b1);
        end
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FLASH);
        for (int i = 0; i < 4; i++) begin
            ld(AD, 1'b0, wal[i]);
            rd(1'b0, {1'b0, wlo[i]});
            rd(1'b1, {1'b0, whi[i]});
        end
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_EEPROM);
        ld(AD, 1'b1, 8'h01);
        ld(AD, 1'b0, wal[0]);
        ld(DT, 1'b0, whi[0]);
        wrb(1'b0);
        // strobe longer than the programming time: no busy pulse
        ld(AD, 1'b0, wal[1]);
        ld(DT, 1'b0, wlo[1]);
        i_ppp_prog.wr(1'b0, BPC + 10);
        @(negedge sys_clk);
        ck(rdy === 1'b1, "busy after long strobe");
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_EEPROM);
        ld(AD, 1'b0, wal[0]);
        rd(1'b0, {1'b0, whi[0]});
        ld(AD, 1'b0, wal[1]);
        rd(1'b0, {1'b0, wlo[1]});
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FUSE);
        ld(DT, 1'b0, 8'hDE);
        i_ppp_prog.wr(1'b0, 8);
        ck(fuse === 2'b00 && rdy === 1'b1, "fuse write");
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_LOCK);
        for (int i = 0; i < 3; i++) begin
            ld(DT, 1'b0, lk_d[i]);
            i_ppp_prog.wr(1'b0, 2);
            repeat (2) @(negedge sys_clk);
            ck(lock === lk_e[i], "lock write");
        end
        // unknown command: no write effect, bus stays released
        ld(`PPP_ACT_CMD, 1'b0, 8'h55);
        ld(DT, 1'b0, 8'hFF);
        i_ppp_prog.wr(1'b0, 2);
        rd(1'b0, {1'b1, 8'h00});
        ck(lock === 2'b00 && fuse === 2'b00, "unknown command");
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_LOCK);
        rd(1'b1, {1'b0, 3'b000, 4'hF, 1'b0});
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_SIG);
        for (int i = 0; i < 4; i++) begin
            ld(AD, 1'b0, 8'(i));
            rd(1'b0, {1'b0, SIG[i]});
        end
        ld(AD, 1'b0, 8'h00);
        ld(`PPP_ACT_IDLE, 1'b0, 8'h03);
        rd(1'b0, {1'b0, SIG[0]});
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_ERASE);
        i_ppp_prog.wr(1'b0, 6);
        ck(lock === 2'b11 && fuse === 2'b00, "erase");
        ld(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FLASH);
        ld(AD, 1'b1, 8'h05);
        ld(AD, 1'b0, wal[2]);
        rd(1'b1, {1'b0, 8'hFF});
        repeat (2) @(negedge sys_clk);
        report_and_stop();
    end
endmodule // ppp_port_test
`default_nettype wire

// >>> bench/ppp_prog.sv
/* programmer model: drives the port's pins from tasks.
   assumes the device clock; pins move at its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module ppp_prog (
    input  wire logic       clk_i,
    input  wire logic [7:0] dev_data_i,
    input  wire logic       dev_oe_n_i,
    output logic            ls_o,
    output logic [1:0]      act_o,
    output logic            bs_o,
    output logic            wr_n_o,
    output logic            oe_n_o,
    output logic            smp_o,
    output logic [7:0]      bus_o
);
    logic [7:0] dq = 8'h00;
    logic       drv = 1'b0;
    // ==================================================================
    // bus level: released lines show the inverse, never a stale value
    assign bus_o = !dev_oe_n_i ? dev_data_i : (drv ? dq : ~dq);
    initial begin
        {ls_o, bs_o, smp_o} = 3'b000;
        {wr_n_o, oe_n_o} = 2'b11;
        act_o = 2'b11;
    end
    // one load strobe; data held until the strobe has been sampled
    task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
        @(negedge clk_i);
        {act_o, bs_o, dq, drv} = {a, b, d, 1'b1};
        @(negedge clk_i);
        ls_o = 1'b1;
        @(negedge clk_i);
        {ls_o, drv, act_o} = 4'b0011;
    endtask
    // write strobe low for n cycles, byte select set one cycle ahead
    task automatic wr(input logic b, input int n);
        @(negedge clk_i);
        bs_o = b;
        @(negedge clk_i);
        wr_n_o = 1'b0;
        repeat (n) @(negedge clk_i);
        wr_n_o = 1'b1;
    endtask
    // output enable low, sample flag once data has settled
    task automatic rd(input logic b);
        @(negedge clk_i);
        {bs_o, oe_n_o} = {b, 1'b0};
        repeat (2) @(negedge clk_i);
        smp_o = 1'b1;
        @(negedge clk_i);
        {smp_o, oe_n_o} = 2'b01;
    endtask
endmodule // ppp_prog
`default_nettype wire

// >>> rtl/ppp_defs.vh
/*
 * shared constants of the parallel programming port: action codes,
 * command bytes, fuse and lock bit positions, timing figures.
 * assumes inclusion by bare name from the design files under rtl/.
 */
`ifndef PPP_DEFS_VH
`define PPP_DEFS_VH

// =====================================================================
// load strobe action codes
`define PPP_ACT_ADDR      2'b00
`define PPP_ACT_DATA      2'b01
`define PPP_ACT_CMD       2'b10
`define PPP_ACT_IDLE      2'b11

// =====================================================================
// command bytes
`define PPP_CMD_ERASE     8'h80
`define PPP_CMD_WR_FUSE   8'h40
`define PPP_CMD_WR_LOCK   8'h20
`define PPP_CMD_WR_FLASH  8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_RD_SIG    8'h08
`define PPP_CMD_RD_LOCK   8'h04
`define PPP_CMD_RD_FLASH  8'h02
`define PPP_CMD_RD_EEPROM 8'h03

// =====================================================================
// bit positions in fuse/lock write and readback bytes
`define PPP_FUSE_SERIAL_PROG_ENABLE_FUSE_BIT 5
`define PPP_FUSE_FAST_START_FUSE_BIT 0
`define PPP_LOCK_TWO_BIT   2
`define PPP_LOCK_ONE_BIT   1
`define PPP_RB_LOCK1_BIT   7
`define PPP_RB_LOCK2_BIT   6

// =====================================================================
// reset values and erased contents
`define PPP_ERASED_BYTE   8'hFF
`define PPP_LOCK_RESET    2'b11
`define PPP_FUSE_RESET    2'b11

// =====================================================================
// timing: clock rate and byte programming time (0.5 to 0.9 ms window)
`define PPP_CLK_KHZ       40000
`define PPP_BYTE_PROG_US  700

`endif

// >>> rtl/ppp_fifo.v
/*
 * small synchronous fifo in flip-flops, width and depth as parameters.
 * assumes one clock and an asynchronous active-low reset copy from the
 * instantiating module; depth is a power of two.
 */
`timescale 1ns/1ps
`default_nettype none

module ppp_fifo #(
    parameter W  = 8,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire         clk_i,
    input  wire         rstn_i,
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem_q [0:D-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0]   cnt_q;
    wire         push;
    wire         pop;

    // =================================================================
    // flags derive from the occupancy count, so full and empty are exact
    assign in_ready_o  = (cnt_q != D[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // storage has no reset; only pointers and count carry control state
    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // pointers and count
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            cnt_q    <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // ppp_fifo

`default_nettype wire

// >>> rtl/ppp_port.v
/*
 * parallel programming port: latches command, address and data on the
 * load strobe, performs flash/eeprom byte writes, fuse and lock writes,
 * chip erase and all readbacks, and drives the ready/busy flag.
 * assumes every pin input is synchronous to sys_clk_i; the load strobe
 * is sampled, not used as a clock. memories are flip-flop arrays.
 */
// Contract
// - command and address stay latched between operations
// - flash read: byte select picks low/high
// - eeprom read drives addressed byte
// - fuse write: bit5 serial enable, bit0 faststart
// - fuse write leaves ready/busy untouched
// - lock write: bits 2,1, zero programs
// - only chip erase clears lock bits
// - lock/fuse readback on bits 7,6,5,0
// - signature read for low address 0..2
// - ready returns 0.5-0.9 ms after write
// - long write pulse hides the busy pulse
// - action bits select address/data/command latch
// - ready/busy low while programming
// - erase memories, then locks; fuses kept
// - flash write: byte select picks half
`timescale 1ns/1ps
`default_nettype none
`include "ppp_defs.vh"

module ppp_port #(
    parameter FLASH_AW      = 12,
    parameter EE_AW         = 9,
    parameter FIFO_DEPTH    = 16,
    parameter BYTE_PROG_CYC = `PPP_BYTE_PROG_US * (`PPP_CLK_KHZ / 1000),
    parameter [7:0] SIG_BYTE0 = 8'h5A, // arbitrary identity value
    parameter [7:0] SIG_BYTE1 = 8'hA5, // arbitrary identity value
    parameter [7:0] SIG_BYTE2 = 8'h3C  // arbitrary identity value
) (
    input  wire       sys_clk_i,
    input  wire       rstn_i,
    input  wire       load_strobe_clock_i,
    input  wire       strobe_action_bit0_i,
    input  wire       strobe_action_bit1_i,
    input  wire       byte_select_i,
    input  wire       write_n_i,
    input  wire       output_en_n_i,
    input  wire [7:0] data_i,
    output reg  [7:0] data_o,
    output wire       data_oe_n_o,
    output wire       ready_busy_flag_o,
    output wire [1:0] lock_bits_o,
    output wire [1:0] fuse_bits_o
);
    localparam FW = FLASH_AW + 1;           // byte index: word plus half
    localparam FN = 1 << FW;
    localparam EN = 1 << EE_AW;
    localparam QW = 1 + FW + 8;             // space, index, data
    localparam CW = 16;

    // erase sequencer states
    localparam ER_IDLE = 2'b00;
    localparam ER_MEM  = 2'b01;
    localparam ER_LOCK = 2'b10;

    reg  [1:0]  rst_sync_q;
    wire        rst_n;
    reg  [7:0]  cmd_q;
    reg  [7:0]  addr_hi_q;
    reg  [7:0]  addr_lo_q;
    reg  [7:0]  data_lo_q;
    reg  [7:0]  data_hi_q;
    reg         ls_q;
    reg         wr_n_q;
    reg  [1:0]  lock_q;                     // [1] lock two, [0] lock one
    reg  [1:0]  fuse_q;                     // [1] serial enable, [0] fast
    reg  [1:0]  er_state_q;
    reg  [CW-1:0] timer_q;
    reg  [7:0]  flash_q [0:FN-1];
    reg  [7:0]  ee_q [0:EN-1];
    reg  [7:0]  rd_d;
    wire        ls_rise;
    wire        wr_fall;
    wire [1:0]  action;
    wire [15:0] addr;
    wire [FW-1:0] flash_idx;
    wire        q_in_valid;
    wire        q_in_ready;
    wire [QW-1:0] q_in_data;
    wire        q_out_valid;
    wire        q_out_ready;
    wire [QW-1:0] q_out_data;
    wire        mem_wr;
    wire        wr_byte_cmd;
    integer     i;

    // command class decode, used by the bus driver only
    function is_read;
        input [7:0] c;
        begin
            is_read = (c == `PPP_CMD_RD_SIG)   | (c == `PPP_CMD_RD_LOCK) |
                      (c == `PPP_CMD_RD_FLASH) | (c == `PPP_CMD_RD_EEPROM);
        end
    endfunction

    // =================================================================
    // reset release through two flops
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // =================================================================
    // strobe edges; pins are already synchronous so one flop suffices
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ls_q   <= 1'b0;
            wr_n_q <= 1'b1;
        end else begin
            ls_q   <= load_strobe_clock_i;
            wr_n_q <= write_n_i;
        end
    end
    assign ls_rise = load_strobe_clock_i & ~ls_q;
    assign wr_fall = ~write_n_i & wr_n_q;
    assign action  = {strobe_action_bit1_i, strobe_action_bit0_i};

    // latches hold until overwritten, so they serve many operations
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q     <= 8'h00;
            addr_hi_q <= 8'h00;
            addr_lo_q <= 8'h00;
            data_lo_q <= `PPP_ERASED_BYTE;
            data_hi_q <= `PPP_ERASED_BYTE;
        end else if (ls_rise) begin
            case (action)
                `PPP_ACT_ADDR: begin
                    if (byte_select_i) begin
                        addr_hi_q <= data_i;
                    end else begin
                        addr_lo_q <= data_i;
                    end
                end
                `PPP_ACT_DATA: begin
                    if (byte_select_i) begin
                        data_hi_q <= data_i;
                    end else begin
                        data_lo_q <= data_i;
                    end
                end
                `PPP_ACT_CMD: begin
                    cmd_q <= data_i;
                end
                default: begin
                    cmd_q <= cmd_q;                        // idle code
                end
            endcase
        end
    end

    assign addr      = {addr_hi_q, addr_lo_q};
    assign flash_idx = {addr[FLASH_AW-1:0], byte_select_i};

    // =================================================================
    // byte writes queue up; the drain side commits one entry per
    // cycle once the timer has run out, and a full queue shows as busy to stall the host
    assign wr_byte_cmd = (cmd_q == `PPP_CMD_WR_FLASH) |
                         (cmd_q == `PPP_CMD_WR_EEPROM);
    assign q_in_valid  = wr_fall & wr_byte_cmd & (er_state_q == ER_IDLE);
    assign q_in_data   = (cmd_q == `PPP_CMD_WR_FLASH) ?
                         {1'b1, flash_idx,
                          (byte_select_i ? data_hi_q : data_lo_q)} :
                         {1'b0, {(FW-EE_AW){1'b0}}, addr[EE_AW-1:0],
                          data_lo_q};
    assign q_out_ready = (timer_q == {CW{1'b0}});
    assign mem_wr      = q_out_valid & q_out_ready;

    ppp_fifo #(
        .W  (QW),
        .D  (FIFO_DEPTH),
        .AW (4)
    ) u_wr_fifo (
        .clk_i       (sys_clk_i),
        .rstn_i      (rst_n),
        .in_valid_i  (q_in_valid),
        .in_ready_o  (q_in_ready),
        .in_data_i   (q_in_data),
        .out_valid_o (q_out_valid),
        .out_ready_i (q_out_ready),
        .out_data_o  (q_out_data)
    );

    // programming timer restarts on each accepted write strobe
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            timer_q <= {CW{1'b0}};
        end else if (q_in_valid & q_in_ready) begin
            timer_q <= BYTE_PROG_CYC[CW-1:0];
        end else if (timer_q != {CW{1'b0}}) begin
            timer_q <= timer_q - 1'b1;
        end
    end

    // busy only after the strobe rises; a strobe held past the
    // programming time never shows a busy pulse
    assign ready_busy_flag_o = ~((timer_q != {CW{1'b0}}) & write_n_i)
                               & q_in_ready;

    // =================================================================
    // erase: memories in one cycle, then lock bits in the next
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            er_state_q <= ER_IDLE;
        end else begin
            case (er_state_q)
                ER_IDLE: begin
                    if (wr_fall & (cmd_q == `PPP_CMD_ERASE) & ~q_out_valid)
                    begin
                        er_state_q <= ER_MEM;
                    end
                end
                ER_MEM: begin
                    er_state_q <= ER_LOCK;
                end
                default: begin
                    er_state_q <= ER_IDLE;
                end
            endcase
        end
    end

    // memory arrays: erase fills, drained queue entries write
    always @(posedge sys_clk_i) begin
        for (i = 0; i < FN; i = i + 1) begin
            if (er_state_q == ER_MEM) begin
                flash_q[i] <= `PPP_ERASED_BYTE;
            end else if (mem_wr & q_out_data[QW-1] &
                         (q_out_data[QW-2:8] == i[FW-1:0])) begin
                flash_q[i] <= q_out_data[7:0];
            end
        end
        for (i = 0; i < EN; i = i + 1) begin
            if (er_state_q == ER_MEM) begin
                ee_q[i] <= `PPP_ERASED_BYTE;
            end else if (mem_wr & ~q_out_data[QW-1] &
                         (q_out_data[EE_AW+7:8] == i[EE_AW-1:0])) begin
                ee_q[i] <= q_out_data[7:0];
            end
        end
    end

    // =================================================================
    // fuse and lock bits; lock can only be programmed here, never
    // cleared, so a protected part cannot be unlocked without erase
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= `PPP_LOCK_RESET;
            fuse_q <= `PPP_FUSE_RESET;
        end else begin
            if (er_state_q == ER_LOCK) begin
                lock_q <= `PPP_LOCK_RESET;
            end else if (wr_fall & ~byte_select_i &
                         (cmd_q == `PPP_CMD_WR_LOCK)) begin
                lock_q <= lock_q & {data_lo_q[`PPP_LOCK_TWO_BIT],
                                    data_lo_q[`PPP_LOCK_ONE_BIT]};
            end
            // no timer start, so ready/busy stays put
            if (wr_fall & (cmd_q == `PPP_CMD_WR_FUSE)) begin
                fuse_q <= {data_lo_q[`PPP_FUSE_SERIAL_PROG_ENABLE_FUSE_BIT],
                           data_lo_q[`PPP_FUSE_FAST_START_FUSE_BIT]};
            end
        end
    end
    assign lock_bits_o = lock_q;
    assign fuse_bits_o = fuse_q;

    // =================================================================
    // readback mux, registered onto the data output
    always @* begin
        rd_d = data_o;
        case (cmd_q)
            `PPP_CMD_RD_FLASH: begin
                rd_d = flash_q[flash_idx];
            end
            `PPP_CMD_RD_EEPROM: begin
                rd_d = ee_q[addr[EE_AW-1:0]];
            end
            `PPP_CMD_RD_LOCK: begin
                rd_d = byte_select_i ?
                       {lock_q[0], lock_q[1], fuse_q[1], 4'hF, fuse_q[0]} :
                       8'hFF;
            end
            `PPP_CMD_RD_SIG: begin
                case (addr_lo_q)
                    8'h00:   rd_d = SIG_BYTE0;
                    8'h01:   rd_d = SIG_BYTE1;
                    8'h02:   rd_d = SIG_BYTE2;
                    default: rd_d = 8'hFF;
                endcase
            end
            default: begin
                rd_d = 8'h00;
            end
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            data_o <= 8'h00;
        end else begin
            data_o <= rd_d;
        end
    end

    // drive only for a read command with output enable low
    assign data_oe_n_o = ~(~output_en_n_i & is_read(cmd_q));
endmodule // ppp_port

`default_nettype wire
